// file: src/plcled_pkg.sv
// Package for the front-panel status indicator encoder.
// Assumes a single 10 MHz system clock shared with the status logic.
package plcled_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_TIME_NS  = 1000000;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // Flash periods in milliseconds; the frame must be a multiple of each
  localparam logic [10:0] INIT_FLASH_MS = 11'h7D0;
  localparam logic [10:0] EXCH_FLASH_MS = 11'h190;
  localparam logic [10:0] GEN_FLASH_MS  = 11'h3E8;
  localparam logic [10:0] FRAME_MS      = 11'h7D0;

  // ****************************************************************
  // Lamp positions and reset value
  // ****************************************************************
  localparam int unsigned LAMP_READY   = 0;
  localparam int unsigned LAMP_ERROR   = 1;
  localparam int unsigned LAMP_PROGRUN = 2;
  localparam int unsigned LAMP_USER    = 3;
  localparam int unsigned LAMP_BATTERY = 4;
  localparam int unsigned LAMP_CARD    = 5;
  localparam int unsigned LAMP_COUNT   = 6;
  localparam logic        LAMP_RESET   = 1'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PLCLED_ERR_NONE     = 2'h0,
    PLCLED_ERR_MINOR    = 2'h1,
    PLCLED_ERR_MODERATE = 2'h2,
    PLCLED_ERR_MAJOR    = 2'h3
  } plcled_err_t;

  typedef enum logic [1:0] {
    PLCLED_CPU_STOP  = 2'h0,
    PLCLED_CPU_RUN   = 2'h1,
    PLCLED_CPU_PAUSE = 2'h2
  } plcled_cpu_t;

  typedef enum logic [1:0] {
    PLCLED_CARD_ABSENT   = 2'h0,
    PLCLED_CARD_UNUSABLE = 2'h1,
    PLCLED_CARD_READYING = 2'h2,
    PLCLED_CARD_USABLE   = 2'h3
  } plcled_card_t;

  // Undetermined -> control or standby; control <-> standby flips one bit
  typedef enum logic [1:0] {
    PLCLED_ROLE_UNDET   = 2'h0,
    PLCLED_ROLE_CONTROL = 2'h1,
    PLCLED_ROLE_STANDBY = 2'h3
  } plcled_role_t;

  typedef enum logic [2:0] {
    PLCLED_LAMP_OFF   = 3'h0,
    PLCLED_LAMP_ON    = 3'h1,
    PLCLED_LAMP_FINIT = 3'h2,
    PLCLED_LAMP_FEXCH = 3'h3,
    PLCLED_LAMP_FGEN  = 3'h4
  } plcled_mode_t;

  typedef struct packed {
    logic         init_busy;
    logic         online_exchange;
    plcled_err_t  err_level;
    plcled_cpu_t  cpu_state;
    logic         stop_error;
    logic         run_wait;
    logic         both_running;
    logic         redundant;
    logic         backup_mode;
    logic         battery_low;
    plcled_card_t card_state;
  } plcled_status_t;

  typedef struct packed {
    logic ready;
    logic error;
    logic program_run;
    logic user;
    logic battery;
    logic card_ready;
  } plcled_lamps_t;

endpackage

// file: src/plcled_encoder.sv
// Front-panel status indicator encoder: turns CPU status into lamp drive.
// Assumes all status inputs come from logic on sys_clk; lamps are driven
// active high, one bit per lamp.
`timescale 1ns/10ps
`default_nettype none

module plcled_encoder #(
  parameter int unsigned ANN_WIDTH   = 8,
  parameter int unsigned TICK_CYCLES = plcled_pkg::TICK_CYCLES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire plcled_pkg::plcled_status_t status,
  input  wire logic [ANN_WIDTH-1:0]      annunciator,
  input  wire logic                      system_a_strap,
  input  wire logic                      start_both,
  input  wire logic                      role_switch,
  output      plcled_pkg::plcled_lamps_t lamps,
  output      logic                      control_system_indicator,
  output      logic                      standby_system_indicator
);
  import plcled_pkg::*;

  localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end
  if (ANN_WIDTH < 1) begin : g_bad_ann
    $error("ANN_WIDTH must be at least one");
  end
  // Flash periods must tile the frame, or the phase jumps at the wrap
  if ((FRAME_MS % INIT_FLASH_MS) != 11'h000) begin : g_bad_init
    $error("FRAME_MS must be a multiple of INIT_FLASH_MS");
  end
  if ((FRAME_MS % EXCH_FLASH_MS) != 11'h000) begin : g_bad_exch
    $error("FRAME_MS must be a multiple of EXCH_FLASH_MS");
  end
  if ((FRAME_MS % GEN_FLASH_MS) != 11'h000) begin : g_bad_gen
    $error("FRAME_MS must be a multiple of GEN_FLASH_MS");
  end
  // Odd periods cannot give a 50 percent duty cycle
  if ((INIT_FLASH_MS[0] | EXCH_FLASH_MS[0] | GEN_FLASH_MS[0]) != 1'h0) begin : g_bad_duty
    $error("Flash periods must be even");
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  logic [TICK_W-1:0] tick_cnt;
  logic [10:0]       ms_cnt;
  logic              ms_tick;

  assign ms_tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

  // Free running, never held by status
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tick_cnt <= '0;
    end else if (ms_tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  // Counts milliseconds within one frame
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ms_cnt <= 11'h000;
    end else if (ms_tick) begin
      if (ms_cnt == FRAME_MS - 11'h001) begin
        ms_cnt <= 11'h000;
      end else begin
        ms_cnt <= ms_cnt + 11'h001;
      end
    end
  end

  // First half of each period lit
  logic phase_init;
  logic phase_exch;
  logic phase_gen;

  assign phase_init = (ms_cnt % INIT_FLASH_MS) < (INIT_FLASH_MS >> 1);
  assign phase_exch = (ms_cnt % EXCH_FLASH_MS) < (EXCH_FLASH_MS >> 1);
  assign phase_gen  = (ms_cnt % GEN_FLASH_MS) < (GEN_FLASH_MS >> 1);

  // ****************************************************************
  // Start-up sampling and system role
  // ****************************************************************
  logic         sampled;
  logic         is_system_a;
  plcled_role_t role;

  // Marks that the status inputs have been seen once
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sampled <= 1'h0;
    end else begin
      sampled <= 1'h1;
    end
  end

  // The A/B strap is a board pin: two flops before anything reads it
  // Runs through reset so the value has settled by release
  logic strap_meta;
  logic strap_sync;

  always_ff @(posedge sys_clk) begin
    strap_meta <= system_a_strap;
    strap_sync <= strap_meta;
  end

  // Strap caught on the first edge after reset release
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      is_system_a <= 1'h0;
    end else if (!sampled) begin
      is_system_a <= strap_sync;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      role <= PLCLED_ROLE_UNDET;
    end else begin
      case (role)
        PLCLED_ROLE_UNDET: begin
          if (start_both && sampled) begin
            role <= is_system_a ? PLCLED_ROLE_CONTROL : PLCLED_ROLE_STANDBY;
          end
        end
        // Switching swaps the role only; the A/B strap stays put
        PLCLED_ROLE_CONTROL: begin
          if (role_switch) begin
            role <= PLCLED_ROLE_STANDBY;
          end
        end
        PLCLED_ROLE_STANDBY: begin
          if (role_switch) begin
            role <= PLCLED_ROLE_CONTROL;
          end
        end
        default: begin
          role <= PLCLED_ROLE_UNDET;
        end
      endcase
    end
  end

  // Role indicators follow the role register by one edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      control_system_indicator <= LAMP_RESET;
      standby_system_indicator <= LAMP_RESET;
    end else begin
      control_system_indicator <= (role == PLCLED_ROLE_CONTROL);
      standby_system_indicator <= (role == PLCLED_ROLE_STANDBY);
    end
  end

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  plcled_mode_t mode [LAMP_COUNT];
  plcled_mode_t std_run;
  plcled_mode_t red_run;

  // Standalone and control-system program-run
  always_comb begin
    std_run = PLCLED_LAMP_OFF;
    if (!status.stop_error) begin
      if (status.cpu_state == PLCLED_CPU_RUN) begin
        std_run = PLCLED_LAMP_ON;
      end else if (status.cpu_state == PLCLED_CPU_PAUSE) begin
        std_run = PLCLED_LAMP_FGEN;
      end
    end
  end

  // Redundant program-run by role and operating mode
  always_comb begin
    red_run = PLCLED_LAMP_OFF;
    case (role)
      PLCLED_ROLE_CONTROL: begin
        red_run = std_run;
      end
      PLCLED_ROLE_STANDBY: begin
        if (status.backup_mode) begin
          if (status.both_running) begin
            red_run = std_run;
          end else begin
            red_run = PLCLED_LAMP_OFF;
          end
        end else if (status.stop_error) begin
          red_run = PLCLED_LAMP_OFF;
        end else if (status.cpu_state == PLCLED_CPU_RUN) begin
          red_run = PLCLED_LAMP_ON;
        end else if (status.cpu_state == PLCLED_CPU_PAUSE || status.run_wait) begin
          red_run = PLCLED_LAMP_FGEN;
        end
      end
      default: begin
        red_run = status.run_wait ? PLCLED_LAMP_FGEN : PLCLED_LAMP_OFF;
      end
    endcase
  end

  // Ready and error precedence: init, major, exchange, then level
  always_comb begin
    mode[LAMP_READY] = PLCLED_LAMP_ON;
    mode[LAMP_ERROR] = PLCLED_LAMP_OFF;
    if (status.init_busy) begin
      mode[LAMP_READY] = PLCLED_LAMP_FINIT;
    end else if (status.err_level == PLCLED_ERR_MAJOR) begin
      mode[LAMP_READY] = PLCLED_LAMP_OFF;
      mode[LAMP_ERROR] = status.stop_error ? PLCLED_LAMP_ON : PLCLED_LAMP_FGEN;
    end else if (status.online_exchange) begin
      mode[LAMP_READY] = PLCLED_LAMP_FEXCH;
      if (status.err_level == PLCLED_ERR_MINOR) begin
        mode[LAMP_ERROR] = PLCLED_LAMP_ON;
      end
    end else if (status.err_level == PLCLED_ERR_MINOR) begin
      mode[LAMP_ERROR] = PLCLED_LAMP_ON;
    end else if (status.err_level == PLCLED_ERR_MODERATE) begin
      mode[LAMP_ERROR] = PLCLED_LAMP_FGEN;
    end
    mode[LAMP_PROGRUN] = status.redundant ? red_run : std_run;
    mode[LAMP_USER]    = (|annunciator) ? PLCLED_LAMP_ON : PLCLED_LAMP_OFF;
    mode[LAMP_BATTERY] = status.battery_low ? PLCLED_LAMP_FGEN : PLCLED_LAMP_OFF;
    case (status.card_state)
      PLCLED_CARD_USABLE:   mode[LAMP_CARD] = PLCLED_LAMP_ON;
      PLCLED_CARD_READYING: mode[LAMP_CARD] = PLCLED_LAMP_FGEN;
      default:              mode[LAMP_CARD] = PLCLED_LAMP_OFF;
    endcase
  end

  // ****************************************************************
  // Lamp drive
  // ****************************************************************
  logic lamp_bit [LAMP_COUNT];

  // Each lamp picks its drive from its mode and the shared phases
  for (genvar i = 0; i < LAMP_COUNT; i++) begin : g_lamp
    logic next_lamp;

    always_comb begin
      case (mode[i])
        PLCLED_LAMP_ON:    next_lamp = 1'h1;
        PLCLED_LAMP_FINIT: next_lamp = phase_init;
        PLCLED_LAMP_FEXCH: next_lamp = phase_exch;
        PLCLED_LAMP_FGEN:  next_lamp = phase_gen;
        default:           next_lamp = 1'h0;
      endcase
    end

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        lamp_bit[i] <= LAMP_RESET;
      end else begin
        lamp_bit[i] <= sampled ? next_lamp : LAMP_RESET;
      end
    end
  end

  // ****************************************************************
  // Panel output
  // ****************************************************************
  // One driver for the whole panel word
  assign lamps = '{
    ready:       lamp_bit[LAMP_READY],
    error:       lamp_bit[LAMP_ERROR],
    program_run: lamp_bit[LAMP_PROGRUN],
    user:        lamp_bit[LAMP_USER],
    battery:     lamp_bit[LAMP_BATTERY],
    card_ready:  lamp_bit[LAMP_CARD]
  };

endmodule

`default_nettype wire

// file: sim/plcled_lamp_model.sv
// Lamp observer: watches the panel over a window as an operator would.
// Assumes lamps are registered on sys_clk and active high.
`timescale 1ns/10ps
`default_nettype none
module plcled_lamp_model (
  input  wire logic                      sys_clk,
  input  wire plcled_pkg::plcled_lamps_t lamps,
  input  wire logic                      go,
  input  wire logic [15:0]               win,
  output var  logic                      done,
  output var  logic [5:0]                seen_on,
  output var  logic [5:0]                seen_off,
  output var  int                        run_len
);
  import plcled_pkg::*;
  int   n   = 0;
  int   hi  = 0;
  logic low = 1'b0;
  // Only a high run that starts inside the window counts as whole
  always @(posedge sys_clk) begin
    done <= 1'b0;
    if (go) begin
      n = int'(win);
      hi = 0;
      low = 1'b0;
      seen_on <= '0;
      seen_off <= '0;
      run_len <= 0;
    end else if (n > 0) begin
      n = n - 1;
      seen_on <= seen_on | lamps;
      seen_off <= seen_off | ~lamps;
      if (lamps.ready) begin
        hi = hi + 1;
      end else begin
        if (low && hi > 0) begin
          run_len <= hi;
        end
        hi = 0;
        low = 1'b1;
      end
      if (n == 0) begin
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/plcled_properties.sv
// Checker for the status indicator encoder, bound to its ports.
// Assumes inputs are held steady for a few cycles between changes.
`timescale 1ns/10ps
`default_nettype none
module plcled_properties #(
  parameter int unsigned ANN_WIDTH   = 8,
  parameter int unsigned TICK_CYCLES = 2
) (
  input wire logic                      sys_clk,
  input wire logic                      sys_rst,
  input wire plcled_pkg::plcled_status_t status,
  input wire logic [ANN_WIDTH-1:0]      annunciator,
  input wire logic                      system_a_strap,
  input wire logic                      start_both,
  input wire logic                      role_switch,
  input wire plcled_pkg::plcled_lamps_t lamps,
  input wire logic                      control_system_indicator,
  input wire logic                      standby_system_indicator
);
  import plcled_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Holds off the first edge, where the history of sys_rst is not yet real
  logic past_valid = 1'b0;
  always @(posedge sys_clk) past_valid <= 1'b1;
  // Status held over the last two edges, so either latency reading holds
  sequence settled;
    !sys_rst [*3] ##0 ($past(status, 2) == $past(status));
  endsequence
  reset_lamps_off_a: assert property (disable iff (1'b0)
    past_valid && $past(sys_rst) |-> lamps == '0 && !control_system_indicator)
    else $error("output lit around reset");
  user_lamp_a: assert property (!sys_rst [*3] ##0 ($past(annunciator, 2) ==
    $past(annunciator)) |-> lamps.user == (|$past(annunciator))) else $error("user lamp");
  battery_quiet_a: assert property (settled ##0 !$past(status.battery_low)
    |-> !lamps.battery) else $error("battery lamp lit");
  card_usable_a: assert property (settled ##0 $past(status.card_state) ==
    PLCLED_CARD_USABLE |-> lamps.card_ready) else $error("card lamp not on");
  card_absent_a: assert property (settled ##0 $past(status.card_state) inside
    {PLCLED_CARD_ABSENT, PLCLED_CARD_UNUSABLE} |-> !lamps.card_ready) else $error("card lit");
  init_error_off_a: assert property (settled ##0 $past(status.init_busy)
    |-> !lamps.error) else $error("error lamp lit in init");
  minor_both_on_a: assert property (settled ##0 !$past(status.init_busy) &&
    !$past(status.online_exchange) && $past(status.err_level) == PLCLED_ERR_MINOR
    |-> lamps.ready && lamps.error) else $error("minor error pattern");
  major_ready_off_a: assert property (settled ##0 !$past(status.init_busy) &&
    $past(status.err_level) == PLCLED_ERR_MAJOR |-> !lamps.ready) else $error("ready lit");
  run_lamp_on_a: assert property (settled ##0 !$past(status.redundant) &&
    $past(status.cpu_state) == PLCLED_CPU_RUN && !$past(status.stop_error)
    |-> lamps.program_run) else $error("program-run lamp not on");
  start_role_a: assert property (!sys_rst [*3] ##0 start_both && !$past(start_both) &&
    !control_system_indicator && !standby_system_indicator |-> ##[1:2]
    (control_system_indicator == system_a_strap && standby_system_indicator != system_a_strap))
    else $error("role after start");
  cover property (role_switch && control_system_indicator);
  cover property (status.online_exchange && lamps.error);
  cover property ($fell(lamps.ready) && status.init_busy);
endmodule
bind plcled_encoder plcled_properties #(
  .ANN_WIDTH   (ANN_WIDTH),
  .TICK_CYCLES (TICK_CYCLES)
) plcled_properties_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .status(status),
  .annunciator(annunciator), .system_a_strap(system_a_strap), .start_both(start_both),
  .role_switch(role_switch), .lamps(lamps), .control_system_indicator(control_system_indicator),
  .standby_system_indicator(standby_system_indicator));
`default_nettype wire

// file: sim/plcled_encoder_tb_top.sv
// Testbench for the status indicator encoder.
// Assumes the lamp observer and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module plcled_encoder_tb_top;
  import plcled_pkg::*;
  localparam int TK = 2;
  localparam logic [1:0] OF = 2'h0, ON = 2'h1, FL = 2'h2, DC = 2'h3;
  typedef struct {logic [11:0] m; int run;} plcled_note_t;
  logic sys_clk = 0, sys_rst = 1, start_both = 0, role_switch = 0, strap = 1, go = 0, done;
  logic ctl, stby;
  plcled_status_t st = '0;
  plcled_lamps_t lamps;
  logic [7:0] ann = '0;
  logic [15:0] win = 16'h17D4;
  logic [5:0] s_on, s_off;
  logic [31:0] seed = 32'hFC885CB1;
  int run_len, failures = 0, tests_run = 0, cyc = 0;
  plcled_note_t q[$], w;
  plcled_encoder #(.ANN_WIDTH(8), .TICK_CYCLES(TK)) plcled_encoder_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .status(st), .annunciator(ann), .system_a_strap(strap),
    .start_both(start_both), .role_switch(role_switch), .lamps(lamps),
    .control_system_indicator(ctl), .standby_system_indicator(stby));
  plcled_lamp_model plcled_lamp_model_i (.sys_clk(sys_clk), .lamps(lamps), .go(go), .win(win),
    .done(done), .seen_on(s_on), .seen_off(s_off), .run_len(run_len));
  always #50 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic err(input string s);
    failures++;
    $display("ERROR %0t %s", $time, s);
  endtask
  task automatic end_sim;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      err("timeout");
      end_sim();
    end
  end
  // Random side lamps ride along with every window
  task automatic chk(input logic [1:0] r, e, p, input int run);
    plcled_note_t n;
    @(negedge sys_clk);
    seed = xs(seed);
    ann = seed[7:0] & {8{seed[8]}};
    st.battery_low = seed[9];
    st.card_state = plcled_card_t'(seed[11:10]);
    n.m = {r, e, p, (|ann) ? ON : OF, st.battery_low ? FL : OF,
      st.card_state == PLCLED_CARD_USABLE ? ON : st.card_state == PLCLED_CARD_READYING ? FL : OF};
    n.run = run;
    q.push_back(n);
    repeat (3) @(negedge sys_clk);
    go = 1;
    @(negedge sys_clk);
    go = 0;
    do @(negedge sys_clk); while (done !== 1'b1);
  endtask
  always @(negedge sys_clk) if (done === 1'b1) begin
    w = q.pop_front();
    for (int i = 0; i < 6; i++) begin
      tests_run++;
      if ((w.m[2*i+:2] == OF && s_on[i] !== 1'b0) || (w.m[2*i+:2] == ON && s_off[i] !== 1'b0) ||
          (w.m[2*i+:2] == FL && (s_on[i] !== 1'b1 || s_off[i] !== 1'b1))) err("lamp pattern");
    end
    tests_run++;
    if (w.run != 0 && run_len != w.run) err("flash on-time");
  end
  task automatic pr(input plcled_cpu_t c, input logic se, input logic [1:0] x);
    st.cpu_state = c;
    st.stop_error = se;
    chk(ON, se ? DC : OF, x, 0);
  endtask
  task automatic std_set;
    pr(PLCLED_CPU_RUN, 0, ON);
    pr(PLCLED_CPU_PAUSE, 0, FL);
    pr(PLCLED_CPU_STOP, 0, OF);
    pr(PLCLED_CPU_RUN, 1, OF);
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1;
    @(negedge sys_clk);
    s = 0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic role_chk(input logic c, s);
    tests_run++;
    if (ctl !== c || stby !== s) err("role indicators");
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    sys_rst = 0;
    st.init_busy = 1;
    chk(FL, OF, OF, 1000 * TK);
    win = 16'h0834;
    st.init_busy = 0;
    chk(ON, OF, OF, 0);
    st.err_level = PLCLED_ERR_MINOR;
    chk(ON, ON, OF, 0);
    st.err_level = PLCLED_ERR_MODERATE;
    chk(ON, FL, OF, 0);
    st.err_level = PLCLED_ERR_MAJOR;
    chk(OF, FL, OF, 0);
    st.stop_error = 1;
    chk(OF, ON, OF, 0);
    st.stop_error = 0;
    st.online_exchange = 1;
    st.err_level = PLCLED_ERR_NONE;
    chk(FL, OF, OF, 200 * TK);
    st.err_level = PLCLED_ERR_MINOR;
    chk(FL, ON, OF, 0);
    st.err_level = PLCLED_ERR_MODERATE;
    chk(FL, OF, OF, 0);
    st.online_exchange = 0;
    st.err_level = PLCLED_ERR_NONE;
    std_set();
    st.redundant = 1;
    st.run_wait = 1;
    pr(PLCLED_CPU_STOP, 0, FL);
    st.run_wait = 0;
    pr(PLCLED_CPU_STOP, 0, OF);
    pulse(start_both);
    role_chk(1, 0);
    std_set();
    pulse(role_switch);
    role_chk(0, 1);
    st.backup_mode = 1;
    st.both_running = 1;
    pr(PLCLED_CPU_RUN, 0, ON);
    pr(PLCLED_CPU_PAUSE, 0, FL);
    pr(PLCLED_CPU_RUN, 1, OF);
    st.both_running = 0;
    pr(PLCLED_CPU_RUN, 0, OF);
    pr(PLCLED_CPU_PAUSE, 0, OF);
    st.backup_mode = 0;
    std_set();
    st.run_wait = 1;
    pr(PLCLED_CPU_STOP, 0, FL);
    sys_rst = 1;
    strap = 0;
    repeat (4) @(negedge sys_clk);
    sys_rst = 0;
    repeat (4) @(negedge sys_clk);
    pulse(start_both);
    role_chk(0, 1);
    end_sim();
  end
endmodule
`default_nettype wire
